// ---- hdl/sfl_loader.sv ----
// Serial firmware upload boot loader, UART, CRC and write buffer
// How it works
// - Serial boot only if both pins low
// - Hold pin high ends boot at once
// - After hold abort wait for reset
// - Send STX once ready for firmware
// - Parse magic, size, binary, CRC in order
// - Size includes trailer; binary is size minus four
// - CRC runs over binary bytes only
// - CRC mismatch answers NAK
// - No first byte in 350 ms gives NAK
// - After that NAK, 100 ms silence, STX
// - Gap over 20 ms gives NAK
// - Size above 32512 gives NAK
// - Clear-error byte acknowledges NAK, then restart
// - Good CRC releases the processor
// - UART 8N1, full duplex
// - Baud pins latched at reset pick rate
`timescale 1ns/100ps
`default_nettype none
module sfl_loader
  import sfl_pkg::*;
#(
  parameter int CLK_HZ = CLK_HZ_DEF,
  parameter logic [15:0] CRC_POLY = CRC_POLY_DEF,
  parameter logic [15:0] CRC_INIT = CRC_INIT_DEF,
  parameter int FIRST_CYC = CLK_HZ / 1000 * FIRST_MS,
  parameter int GAP_CYC = CLK_HZ / 1000 * GAP_MS,
  parameter int SILENCE_CYC = CLK_HZ / 1000 * SILENCE_MS
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic boot_source_select,
  input wire logic upload_hold_pin,
  input wire logic baud_select_low,
  input wire logic baud_select_high,
  input wire logic rx_line,
  output logic tx_line,
  output logic fw_wr_valid,
  input wire logic fw_wr_ready,
  output logic [AW-1:0] fw_wr_addr,
  output logic [7:0] fw_wr_data,
  output logic cpu_release,
  output logic boot_active,
  output logic boot_halted
);
  localparam logic [TMR_W-1:0] FIRST_LIM = TMR_W'(FIRST_CYC);
  localparam logic [TMR_W-1:0] GAP_LIM = TMR_W'(GAP_CYC);
  localparam logic [TMR_W-1:0] SIL_LIM = TMR_W'(SILENCE_CYC);

  typedef struct packed {
    sfl_state_t st;
    logic nak_sil;
    logic [DIV_W-1:0] div;
    logic [TMR_W-1:0] tmr;
    logic [7:0] size_lo;
    logic [15:0] cnt;
    logic [15:0] crc;
    logic [7:0] crc_lo;
    logic [AW-1:0] addr;
    logic rx_busy;
    logic [DIV_W-1:0] rx_cnt;
    logic [3:0] rx_bit;
    logic [7:0] rx_sh;
    logic rx_vld;
    logic [7:0] rx_byte;
    logic tx_busy;
    logic [DIV_W-1:0] tx_cnt;
    logic [3:0] tx_bit;
    logic [8:0] tx_sh;
    logic tx_out;
    logic [1:0][7:0] f_data;
    logic [1:0][AW-1:0] f_addr;
    logic f_wp;
    logic f_rp;
    logic [1:0] f_n;
    logic rel;
  } sfl_state_reg_t;

  sfl_state_reg_t s_q;
  sfl_state_reg_t s_d;
  logic take;
  logic push;
  logic pop;
  logic tx_load;
  logic [7:0] tx_byte;
  logic active;

  function automatic logic [DIV_W-1:0] baud_div(input logic [1:0] code);
    int b;
    case (code)
      2'b00: b = BAUD_00;
      2'b01: b = BAUD_01;
      2'b10: b = BAUD_10;
      default: b = BAUD_11;
    endcase
    return DIV_W'(CLK_HZ / b);
  endfunction

  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  always_comb begin
    s_d = s_q;
    push = 1'b0;
    tx_load = 1'b0;
    tx_byte = STX_BYTE;
    active = (s_q.st != ST_CAPTURE) && (s_q.st != ST_OFF) &&
             (s_q.st != ST_DONE) && (s_q.st != ST_HALT);
    // A full buffer holds the byte in the receiver instead of dropping it
    take = s_q.rx_vld && !((s_q.st == ST_BIN) && (s_q.f_n == BUF_DEPTH));
    pop = fw_wr_valid && fw_wr_ready;
    if (s_q.tmr != {TMR_W{1'b1}}) begin
      s_d.tmr = s_q.tmr + TMR_W'(1);
    end
    if (take) begin
      s_d.rx_vld = 1'b0;
      s_d.tmr = '0;
    end
    case (s_q.st)
      ST_CAPTURE: begin
        s_d.div = baud_div({baud_select_high, baud_select_low});
        if (!boot_source_select && !upload_hold_pin) begin
          s_d.st = ST_SEND_STX;
        end else begin
          s_d.st = ST_OFF;
        end
      end
      ST_SEND_STX: begin
        if (!s_q.tx_busy) begin
          tx_load = 1'b1;
          s_d.st = ST_WAIT_FIRST;
          s_d.tmr = '0;
        end
      end
      ST_WAIT_FIRST: begin
        if (take) begin
          s_d.st = (s_q.rx_byte == MAGIC_BYTE) ? ST_SIZE_LO : ST_SEND_NAK;
          s_d.nak_sil = 1'b0;
        end else if (s_q.tmr >= FIRST_LIM) begin
          s_d.st = ST_SEND_NAK;
          s_d.nak_sil = 1'b1;
        end
      end
      ST_SIZE_LO, ST_SIZE_HI, ST_BIN, ST_CRC_LO, ST_CRC_HI: begin
        if (take) begin
          case (s_q.st)
            ST_SIZE_LO: begin
              s_d.size_lo = s_q.rx_byte;
              s_d.st = ST_SIZE_HI;
            end
            ST_SIZE_HI: begin
              s_d.cnt = {s_q.rx_byte, s_q.size_lo} - TRAILER_BYTES;
              s_d.crc = CRC_INIT;
              s_d.addr = '0;
              if ({s_q.rx_byte, s_q.size_lo} > MAX_SIZE ||
                  {s_q.rx_byte, s_q.size_lo} < TRAILER_BYTES) begin
                s_d.st = ST_SEND_NAK;
              end else if ({s_q.rx_byte, s_q.size_lo} == TRAILER_BYTES) begin
                s_d.st = ST_CRC_LO;
              end else begin
                s_d.st = ST_BIN;
              end
            end
            ST_BIN: begin
              push = 1'b1;
              s_d.crc = crc_step(s_q.crc, s_q.rx_byte);
              s_d.cnt = s_q.cnt - 16'h0001;
              s_d.addr = s_q.addr + AW'(1);
              if (s_q.cnt == 16'h0001) begin
                s_d.st = ST_CRC_LO;
              end
            end
            ST_CRC_LO: begin
              s_d.crc_lo = s_q.rx_byte;
              s_d.st = ST_CRC_HI;
            end
            default: begin
              if ({s_q.rx_byte, s_q.crc_lo} == s_q.crc) begin
                s_d.st = ST_DRAIN;
              end else begin
                s_d.st = ST_SEND_NAK;
              end
            end
          endcase
        end else if (s_q.tmr >= GAP_LIM) begin
          s_d.st = ST_SEND_NAK;
        end
      end
      ST_DRAIN: begin
        // Release only once every byte has reached memory
        if (s_q.f_n == 2'h0) begin
          s_d.rel = 1'b1;
          s_d.st = ST_DONE;
        end
      end
      ST_SEND_NAK: begin
        if (!s_q.tx_busy) begin
          tx_load = 1'b1;
          tx_byte = NAK_BYTE;
          s_d.st = s_q.nak_sil ? ST_SILENCE : ST_WAIT_CE;
          s_d.tmr = '0;
        end
      end
      ST_SILENCE: begin
        if (!take && s_q.tmr >= SIL_LIM) begin
          s_d.st = ST_SEND_STX;
          s_d.nak_sil = 1'b0;
        end
      end
      ST_WAIT_CE: begin
        if (take && s_q.rx_byte == CLEAR_ERR_BYTE) begin
          s_d.st = ST_SEND_STX;
        end
      end
      default: begin
      end
    endcase
    if (active && upload_hold_pin) begin
      s_d.st = ST_HALT;
      push = 1'b0;
    end

    // Write buffer
    if (push) begin
      s_d.f_data[s_q.f_wp] = s_q.rx_byte;
      s_d.f_addr[s_q.f_wp] = s_q.addr;
      s_d.f_wp = ~s_q.f_wp;
    end
    if (pop) begin
      s_d.f_rp = ~s_q.f_rp;
    end
    s_d.f_n = s_q.f_n + {1'b0, push} - {1'b0, pop};

    // Receiver, 8N1, sampled mid-bit
    if (!s_q.rx_busy) begin
      if (!rx_line && s_q.st != ST_CAPTURE) begin
        s_d.rx_busy = 1'b1;
        s_d.rx_cnt = s_q.div >> 1;
        s_d.rx_bit = 4'h0;
      end
    end else if (s_q.rx_cnt != '0) begin
      s_d.rx_cnt = s_q.rx_cnt - DIV_W'(1);
    end else begin
      s_d.rx_cnt = s_q.div - DIV_W'(1);
      if (s_q.rx_bit == 4'h0) begin
        s_d.rx_busy = !rx_line;
        s_d.rx_bit = 4'h1;
      end else if (s_q.rx_bit != UART_LAST_BIT) begin
        s_d.rx_sh = {rx_line, s_q.rx_sh[7:1]};
        s_d.rx_bit = s_q.rx_bit + 4'h1;
      end else begin
        // Stop bit level is not checked; a late reader sees overrun
        s_d.rx_busy = 1'b0;
        s_d.rx_vld = 1'b1;
        s_d.rx_byte = s_q.rx_sh;
      end
    end

    // Transmitter
    if (tx_load) begin
      s_d.tx_busy = 1'b1;
      s_d.tx_out = 1'b0;
      s_d.tx_sh = {1'b1, tx_byte};
      s_d.tx_bit = 4'h0;
      s_d.tx_cnt = s_q.div - DIV_W'(1);
    end else if (s_q.tx_busy) begin
      if (s_q.tx_cnt != '0) begin
        s_d.tx_cnt = s_q.tx_cnt - DIV_W'(1);
      end else if (s_q.tx_bit == UART_LAST_BIT) begin
        s_d.tx_busy = 1'b0;
      end else begin
        s_d.tx_out = s_q.tx_sh[0];
        s_d.tx_sh = {1'b1, s_q.tx_sh[8:1]};
        s_d.tx_bit = s_q.tx_bit + 4'h1;
        s_d.tx_cnt = s_q.div - DIV_W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
      s_q.st <= ST_CAPTURE;
      s_q.tx_out <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign tx_line = s_q.tx_out;
  assign fw_wr_valid = (s_q.f_n != 2'h0);
  assign fw_wr_addr = s_q.f_addr[s_q.f_rp];
  assign fw_wr_data = s_q.f_data[s_q.f_rp];
  assign cpu_release = s_q.rel;
  assign boot_active = active;
  assign boot_halted = (s_q.st == ST_HALT);
endmodule
`default_nettype wire

// ---- hdl/sfl_pkg.sv ----
// Constants and types shared by the serial firmware upload loader
package sfl_pkg;
  localparam int CLK_HZ_DEF = 200000000;
  localparam int FIRST_MS = 350;
  localparam int GAP_MS = 20;
  localparam int SILENCE_MS = 100;
  localparam int BAUD_00 = 115200;
  localparam int BAUD_01 = 9600;
  localparam int BAUD_10 = 19200;
  localparam int BAUD_11 = 38400;
  localparam int TMR_W = 27;
  localparam int DIV_W = 16;
  localparam int AW = 15;
  localparam logic [7:0] STX_BYTE = 8'h02;
  localparam logic [7:0] NAK_BYTE = 8'h15;
  localparam logic [7:0] MAGIC_BYTE = 8'hAA;
  localparam logic [7:0] CLEAR_ERR_BYTE = 8'hCE;
  localparam logic [15:0] MAX_SIZE = 16'h7F00;
  localparam logic [15:0] TRAILER_BYTES = 16'h0004;
  localparam logic [15:0] CRC_POLY_DEF = 16'h1021;
  localparam logic [15:0] CRC_INIT_DEF = 16'hFFFF;
  localparam logic [3:0] UART_LAST_BIT = 4'h9;
  localparam logic [1:0] BUF_DEPTH = 2'h2;

  typedef enum logic [3:0] {
    ST_CAPTURE, ST_OFF, ST_SEND_STX, ST_WAIT_FIRST, ST_SIZE_LO,
    ST_SIZE_HI, ST_BIN, ST_CRC_LO, ST_CRC_HI, ST_DRAIN, ST_SEND_NAK,
    ST_WAIT_CE, ST_SILENCE, ST_DONE, ST_HALT
  } sfl_state_t;
endpackage

// ---- test/sfl_chk.sv ----
// Port assertions for the upload loader
`timescale 1ns/100ps
`default_nettype none
module sfl_chk
  import sfl_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic boot_source_select,
  input wire logic upload_hold_pin,
  input wire logic tx_line,
  input wire logic fw_wr_valid,
  input wire logic fw_wr_ready,
  input wire logic [AW-1:0] fw_wr_addr,
  input wire logic [7:0] fw_wr_data,
  input wire logic cpu_release,
  input wire logic boot_active,
  input wire logic boot_halted
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  property p_off;
    $rose(rst_b) && boot_source_select |-> !boot_active [*8];
  endproperty
  a_off: assert property (p_off) else $error("loader ran");
  property p_stx;
    $rose(rst_b) && !boot_source_select && !upload_hold_pin
      |-> ##[1:3] !tx_line;
  endproperty
  a_stx: assert property (p_stx) else $error("no start");
  property p_hold;
    boot_active && upload_hold_pin |-> ##[1:2] boot_halted;
  endproperty
  a_hold: assert property (p_hold) else $error("no halt");
  property p_sticky;
    boot_halted |=> boot_halted && !boot_active && !cpu_release;
  endproperty
  a_sticky: assert property (p_sticky) else $error("left halt");
  property p_nopush;
    boot_halted && !fw_wr_valid |=> !fw_wr_valid;
  endproperty
  a_nopush: assert property (p_nopush) else $error("push");
  property p_rel;
    cpu_release |-> !fw_wr_valid ##1 cpu_release;
  endproperty
  a_rel: assert property (p_rel) else $error("release");
  // Memory may stall for long; entry must hold
  property p_stable;
    fw_wr_valid && !fw_wr_ready
      |=> fw_wr_valid && $stable(fw_wr_addr) && $stable(fw_wr_data);
  endproperty
  a_stable: assert property (p_stable) else $error("moved");
  property p_addr;
    fw_wr_valid && fw_wr_ready ##1 fw_wr_valid
      |-> fw_wr_addr == $past(fw_wr_addr) + 15'h0001;
  endproperty
  a_addr: assert property (p_addr) else $error("address");
endmodule
`default_nettype wire

// ---- test/sfl_host.sv ----
// Host controller model on the serial link
`timescale 1ns/100ps
`default_nettype none
module sfl_host (
  input wire logic sys_clk,
  input wire logic tx_line,
  output logic rx_line
);
  int div = 10;
  logic [7:0] got[$];
  initial rx_line = 1'b1;
  // 8N1, LSB first, idle high
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    @(negedge sys_clk);
    for (int i = 0; i < 10; i++) begin
      rx_line = f[i];
      repeat (div) @(negedge sys_clk);
    end
  endtask
  // Listens all the time; a reply may start before send returns
  always begin : listen
    logic [7:0] b;
    @(negedge sys_clk iff tx_line === 1'b0);
    repeat (div / 2) @(negedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (div) @(negedge sys_clk);
      b[i] = tx_line;
    end
    repeat (div) @(negedge sys_clk);
    got.push_back(b);
  end
endmodule
`default_nettype wire

// ---- test/testbench.sv ----
// Self-checking bench for the upload loader
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((e) !== (s)) begin \
  num_errors++; $display("BAD %s exp %0h got %0h", n, e, s); end end
module testbench;
  import sfl_pkg::*;
  logic sys_clk = 0, rst_b = 0, sel = 0, hold = 0, bl = 0, bh = 0;
  logic fw_wr_ready = 0;
  logic rx_line, tx_line, fw_wr_valid, cpu_release, boot_active;
  logic boot_halted;
  logic [AW-1:0] fw_wr_addr;
  logic [7:0] fw_wr_data;
  logic [15:0] pops[$];
  int num_errors = 0, cmp_count = 0, cyc = 0, t0;
  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (fw_wr_valid && fw_wr_ready)
      pops.push_back({fw_wr_addr[7:0], fw_wr_data});
    if (cyc == 50000) begin
      num_errors++;
      summarize();
    end
  end
  // Short timeouts keep the run small; each exceeds a byte time, except the gap limit at code 01
  sfl_loader #(.CLK_HZ(1152000), .FIRST_CYC(3000), .GAP_CYC(1000),
    .SILENCE_CYC(2000)) sfl_loader_inst (.sys_clk, .rst_b,
    .boot_source_select(sel), .upload_hold_pin(hold),
    .baud_select_low(bl), .baud_select_high(bh), .rx_line, .tx_line,
    .fw_wr_valid, .fw_wr_ready, .fw_wr_addr, .fw_wr_data, .cpu_release,
    .boot_active, .boot_halted);
  sfl_host sfl_host_inst (.sys_clk, .tx_line, .rx_line);
  task automatic summarize();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic reset_dut(input logic s, input logic h, input logic l);
    @(negedge sys_clk);
    rst_b = 0;
    sel = s;
    bh = h;
    bl = l;
    hold = 0;
    fw_wr_ready = 0;
    sfl_host_inst.div = 1152000 /
      (h ? (l ? BAUD_11 : BAUD_10) : (l ? BAUD_01 : BAUD_00));
    repeat (8) @(negedge sys_clk);
    rst_b = 1;
    pops.delete();
    sfl_host_inst.got.delete();
  endtask
  task automatic tx(input logic [7:0] q[$]);
    foreach (q[i]) sfl_host_inst.send(q[i]);
  endtask
  task automatic exp_byte(input logic [7:0] e);
    while (sfl_host_inst.got.size() == 0) @(negedge sys_clk);
    `CHK("reply", e, sfl_host_inst.got.pop_front())
  endtask
  function automatic logic [15:0] crc(input logic [7:0] q[$]);
    logic [15:0] c;
    c = CRC_INIT_DEF;
    foreach (q[i]) begin
      c = c ^ {q[i], 8'h00};
      for (int k = 0; k < 8; k++)
        c = c[15] ? {c[14:0], 1'b0} ^ CRC_POLY_DEF : {c[14:0], 1'b0};
    end
    return c;
  endfunction
  task automatic t_upload();
    logic [7:0] d[$];
    logic [15:0] c;
    d = '{8'h3C, 8'hA5, 8'h00};
    c = crc(d);
    reset_dut(0, 0, 0);
    exp_byte(STX_BYTE);
    tx('{MAGIC_BYTE, 8'h07, 8'h00});
    tx(d);
    `CHK("full", 1'b1, fw_wr_valid)
    `CHK("stalled", 0, pops.size())
    fw_wr_ready = 1;
    tx('{c[7:0], c[15:8]});
    while (!cpu_release) @(negedge sys_clk);
    `CHK("count", 3, pops.size())
    foreach (d[i]) `CHK("write", {i[7:0], d[i]}, pops[i])
  endtask
  task automatic t_errors();
    logic [15:0] c;
    c = ~crc('{8'h11});
    reset_dut(0, 0, 0);
    fw_wr_ready = 1;
    exp_byte(STX_BYTE);
    tx('{MAGIC_BYTE, 8'h05, 8'h00, 8'h11, c[7:0], c[15:8]});
    exp_byte(NAK_BYTE);
    tx('{CLEAR_ERR_BYTE});
    exp_byte(STX_BYTE);
    tx('{MAGIC_BYTE, 8'h01, 8'h7F});
    exp_byte(NAK_BYTE);
    tx('{CLEAR_ERR_BYTE});
    exp_byte(STX_BYTE);
    tx('{MAGIC_BYTE, 8'h00, 8'h7F});
    repeat (800) @(negedge sys_clk);
    `CHK("quiet", 0, sfl_host_inst.got.size())
    exp_byte(NAK_BYTE);
    tx('{CLEAR_ERR_BYTE});
    exp_byte(STX_BYTE);
  endtask
  task automatic t_first();
    reset_dut(0, 1, 1);
    exp_byte(STX_BYTE);
    t0 = cyc;
    exp_byte(NAK_BYTE);
    `CHK("first", 1'b1, (cyc - t0) inside {[2900:3100]})
    t0 = cyc;
    exp_byte(STX_BYTE);
    `CHK("silence", 1'b1, (cyc - t0) inside {[1900:2200]})
  endtask
  task automatic t_halt();
    // Code 10 keeps a byte time under the shortened gap limit
    reset_dut(0, 1, 0);
    fw_wr_ready = 1;
    exp_byte(STX_BYTE);
    tx('{MAGIC_BYTE});
    hold = 1;
    repeat (2) @(negedge sys_clk);
    `CHK("halted", 1'b1, boot_halted)
    hold = 0;
    tx('{8'h05, 8'h00, 8'h42});
    repeat (1500) @(negedge sys_clk);
    `CHK("active", 1'b0, boot_active)
    `CHK("silent", 0, sfl_host_inst.got.size() + pops.size())
  endtask
  task automatic t_off();
    reset_dut(1, 0, 1);
    repeat (500) @(negedge sys_clk);
    `CHK("off", 1'b0, boot_active)
    `CHK("no stx", 0, sfl_host_inst.got.size())
  endtask
  initial begin
    t_upload();
    t_errors();
    t_first();
    t_halt();
    t_off();
    summarize();
  end
endmodule
bind sfl_loader sfl_chk sfl_chk_inst (.sys_clk, .rst_b,
  .boot_source_select, .upload_hold_pin, .tx_line, .fw_wr_valid,
  .fw_wr_ready, .fw_wr_addr, .fw_wr_data, .cpu_release, .boot_active,
  .boot_halted);
`default_nettype wire
